// >>> include/adc_cfg_pkg.sv
// Constants and carrier types of the converter configuration register bank.
// Assumes a 32-bit APB slave, one register per aligned word at four times its index.
package adc_cfg_pkg;

	// ----------------------------------------
	// Register indices and bus geometry
	// ----------------------------------------
	localparam int unsigned ADDR_W      = 14;       // Byte address width
	localparam int unsigned DATA_W      = 32;       // Bus data width
	localparam int unsigned REG_W       = 8;        // Register width
	localparam logic [11:0] IDX_READY   = 12'h025;  // Config ready status
	localparam logic [11:0] IDX_SOFTRST = 12'h100;  // Soft reset control
	localparam logic [11:0] IDX_PDN     = 12'h101;  // Global power down
	localparam logic [11:0] IDX_SYNCCLR = 12'h102;  // Sync detect clear
	localparam logic [11:0] IDX_TERM    = 12'h104;  // Input termination
	localparam logic [11:0] IDX_OVRCTL  = 12'h10A;  // Overrange control
	localparam logic [11:0] IDX_OVRLEN  = 12'h10B;  // Overrange stretch length
	localparam logic [11:0] IDX_OUTCTL  = 12'h110;  // Output link control
	localparam logic [11:0] IDX_FLAGS   = 12'h140;  // Flag register
	localparam logic [1:0]  WORD_LSBS   = 2'h0;     // Byte offset inside a word

	// ----------------------------------------
	// Field positions, codes and reset values
	// ----------------------------------------
	localparam int unsigned BIT_READY     = 4;
	localparam int unsigned BIT_SOFTRST   = 0;
	localparam int unsigned BIT_PDN       = 4;
	localparam int unsigned BIT_SYNCCLR   = 6;
	localparam int unsigned BIT_TERM_A    = 0;
	localparam int unsigned BIT_TERM_B    = 1;
	localparam int unsigned BIT_STICKY    = 0;
	localparam int unsigned BIT_CLR_LO    = 1;
	localparam int unsigned BIT_CLR_HI    = 2;
	localparam int unsigned BIT_LINKTERM  = 7;
	localparam int unsigned BIT_HALFSWING = 5;
	localparam int unsigned BIT_ORDER     = 1;
	localparam int unsigned BIT_SYNCFLAG  = 6;
	localparam logic [1:0]  OVR_CLR_CODE  = 2'h2;   // Clear code of the sticky flag
	localparam logic [7:0]  RST_ZERO      = 8'h00;
	localparam logic [7:0]  RST_OUTCTL    = 8'h02;  // Normal channel order
	localparam logic [7:0]  RST_OVRLEN    = 8'h00;

	// ----------------------------------------
	// Sample path and timing
	// ----------------------------------------
	localparam int unsigned SAMPLE_W      = 16;
	localparam logic [15:0] FULL_SCALE_HI = 16'h7FFF;  // Positive limit
	localparam logic [15:0] FULL_SCALE_LO = 16'h8000;  // Negative limit
	localparam int unsigned FUSE_CYCLES   = 64;        // Fuse load duration

	// Fuse loader states
	typedef enum logic [1:0]
	{
		FUSE_LOADING = 2'b01,
		FUSE_DONE    = 2'b10
	} fuse_state_e;

	// Analog and link controls driven out of the bank
	typedef struct packed
	{
		logic globalPowerdown;      // Whole device powered down
		logic chanBInputTermination; // 1: 200 ohm, 0: 100 ohm
		logic chanAInputTermination; // 1: 200 ohm, 0: 100 ohm
		logic linkTerm100;          // 1: 100 ohm, 0: 50 ohm
		logic halfSwing;            // Output swing cut to half
	} analog_ctrl_s;

	// One converted sample pair
	typedef struct packed
	{
		logic                valid;
		logic [SAMPLE_W-1:0] chanA;
		logic [SAMPLE_W-1:0] chanB;
	} sample_pair_s;

endpackage : adc_cfg_pkg

// >>> design/fuse_loader.sv
// Fuse load sequencer: raises the ready level a fixed time after hardware reset.
// Assumes only the hardware reset restarts it, never the soft reset.
`timescale 1ns/1ps

module fuse_loader
#(
	parameter int unsigned LOAD_CYCLES = adc_cfg_pkg::FUSE_CYCLES
)
(
	// Clock and control
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic clkEn,
	// Status
	output logic      configReady
);

	localparam int unsigned CNT_W = $clog2(LOAD_CYCLES + 1);

	adc_cfg_pkg::fuse_state_e state_q;  // Load progress
	logic [CNT_W-1:0]         count_q;  // Cycles spent loading

	// ----------------------------------------
	// Load counter and state
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_q <= adc_cfg_pkg::FUSE_LOADING;
			count_q <= '0;
		end
		else if (clkEn)
		begin
			unique case (state_q)
				// Counting out the fuse transfer
				adc_cfg_pkg::FUSE_LOADING:
				begin
					if (count_q == CNT_W'(LOAD_CYCLES - 1))
						state_q <= adc_cfg_pkg::FUSE_DONE;
					count_q <= count_q + 1'b1;
				end
				// Fuses applied, stay here
				adc_cfg_pkg::FUSE_DONE:
					state_q <= adc_cfg_pkg::FUSE_DONE;
				default:
					state_q <= adc_cfg_pkg::FUSE_LOADING;
			endcase
		end
	end

	assign configReady = (state_q == adc_cfg_pkg::FUSE_DONE);

endmodule : fuse_loader

// >>> design/overrange_stretch.sv
// One channel's overrange indicator: sticky hold or pulse stretch.
// Assumes the raw event and the clear pulse come from the same clock.
`timescale 1ns/1ps

module overrange_stretch
#(
	parameter int unsigned LEN_W = adc_cfg_pkg::REG_W
)
(
	// Clock and control
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             clkEn,
	// Event and settings
	input  wire logic             rawEvent,
	input  wire logic             sticky,
	input  wire logic             clearPulse,
	input  wire logic [LEN_W-1:0] length,
	// Indicator
	output logic                  overrange
);

	logic [LEN_W-1:0] remain_q;  // Stretch cycles still to go
	logic             flag_q;    // Indicator level

	// ----------------------------------------
	// Sticky hold or stretch countdown
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			flag_q   <= 1'b0;
			remain_q <= '0;
		end
		else if (clkEn)
		begin
			// New event wins over clear and reloads
			if (rawEvent)
			begin
				flag_q   <= 1'b1;
				remain_q <= length;
			end
			// Sticky: hold until the clear code
			else if (sticky)
			begin
				if (clearPulse)
					flag_q <= 1'b0;
			end
			// Stretch: N further cycles after the first
			else if (remain_q != '0)
				remain_q <= remain_q - 1'b1;
			else
				flag_q <= 1'b0;
		end
	end

	assign overrange = flag_q;

endmodule : overrange_stretch

// >>> design/adc_config_status_register_bank.sv
// Configuration and status register bank of a dual-channel converter.
// Assumes an APB master on core_clk, samples on core_clk and a sync pin
// from outside the clock domain.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Status bit 4 shows fuse load done
// - Soft reset restores defaults, self clears
// - Power-down bit drives global power down
// - Held clear bit resets sync detect flag
// - Per-channel termination select, 100 or 200
// - Sticky bit chooses hold or stretch
// - Clear code two drops sticky overrange
// - Length N gives N+1 cycles asserted
// - Link termination bit: 100 or 50 ohm
// - Half swing bit cuts output swing
// - Order bit low swaps channel data
module adc_config_status_register_bank
#(
	parameter int unsigned FUSE_LOAD_CYCLES = adc_cfg_pkg::FUSE_CYCLES,
	parameter int unsigned LEN_W            = adc_cfg_pkg::REG_W
)
(
	// Clock, reset and enable
	input  wire logic                            core_clk,
	input  wire logic                            reset,
	input  wire logic                            clkEn,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [adc_cfg_pkg::DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic                                 pready,
	output logic [adc_cfg_pkg::DATA_W-1:0]       prdata,
	output logic                                 pslverr,
	// Sample path
	input  wire adc_cfg_pkg::sample_pair_s       sampleIn,
	output adc_cfg_pkg::sample_pair_s            sampleOut,
	output logic [1:0]                           overrange,
	// Sync reference pin
	input  wire logic                            syncRefPin,
	// Analog and link controls
	output adc_cfg_pkg::analog_ctrl_s            analogCtrl,
	output logic                                 configReady
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic                    regRst;        // Hardware or soft reset
	logic                    softRst_q;     // Soft reset bit, one cycle
	logic                    pdn_q;         // Global power down
	logic                    syncClr_q;     // Sync detect clear level
	logic [1:0]              term_q;        // Input termination selects
	logic                    sticky_q;      // Overrange sticky mode
	logic [1:0]              ovrClr_q;      // Overrange clear field
	logic [LEN_W-1:0]        ovrLen_q;      // Stretch length
	logic                    linkTerm_q;    // Link termination
	logic                    halfSwing_q;   // Reduced swing
	logic                    order_q;       // Channel order normal
	logic                    syncFlag_q;    // Sync detect flag
	logic                    sync1_q;       // Pin synchroniser stage 1
	logic                    sync2_q;       // Stage 2
	logic                    sync3_q;       // Stage 3
	logic                    syncLvl_q;     // Agreed pin level
	logic                    syncRise;      // Agreed rising edge
	logic                    ready;         // Fuse load done
	logic                    setupPhase;    // APB setup cycle
	logic                    wrAccess;      // Write completing now
	logic [11:0]             regIdx;        // Register index
	logic                    wordAligned;   // Low address bits zero
	logic                    hit;           // Mapped address
	logic                    wrLane;        // Low byte lane written
	logic [7:0]              wrByte;        // Written byte
	logic [7:0]              rdByte;        // Read mux output
	logic [adc_cfg_pkg::DATA_W-1:0] prdata_q; // Read data
	logic                    pslverr_q;     // Error answer
	logic                    ovrClrPulse;   // Clear code written
	logic [1:0]              rawOvr;        // Full-scale events
	logic [adc_cfg_pkg::SAMPLE_W-1:0] chan [2]; // Samples by channel
	adc_cfg_pkg::sample_pair_s sampleOut_q; // Ordered sample pair

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign setupPhase  = psel && !penable;
	assign wrAccess    = psel && penable && pwrite && clkEn;
	assign regIdx      = paddr[adc_cfg_pkg::ADDR_W-1:2];
	assign wordAligned = (paddr[1:0] == adc_cfg_pkg::WORD_LSBS);
	assign wrLane      = pstrb[0];
	assign wrByte      = pwdata[7:0];

	// Mapped index check
	always_comb
	begin
		unique case (regIdx)
			adc_cfg_pkg::IDX_READY,
			adc_cfg_pkg::IDX_SOFTRST,
			adc_cfg_pkg::IDX_PDN,
			adc_cfg_pkg::IDX_SYNCCLR,
			adc_cfg_pkg::IDX_TERM,
			adc_cfg_pkg::IDX_OVRCTL,
			adc_cfg_pkg::IDX_OVRLEN,
			adc_cfg_pkg::IDX_OUTCTL,
			adc_cfg_pkg::IDX_FLAGS: hit = wordAligned;
			default:                hit = 1'b0;
		endcase
	end

	// Zero-wait slave
	assign pready = 1'b1;

	// ----------------------------------------
	// Reset merge
	// ----------------------------------------
	// soft reset acts as reset
	assign regRst = reset || softRst_q;

	always_ff @(posedge core_clk)
	begin
		if (regRst)
			softRst_q <= 1'b0;
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_SOFTRST)
			softRst_q <= wrByte[adc_cfg_pkg::BIT_SOFTRST];
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// power-down bit
	always_ff @(posedge core_clk)
	begin
		if (regRst)
			pdn_q <= adc_cfg_pkg::RST_ZERO[adc_cfg_pkg::BIT_PDN];
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_PDN)
			pdn_q <= wrByte[adc_cfg_pkg::BIT_PDN];
	end

	always_ff @(posedge core_clk)
	begin
		if (regRst)
			syncClr_q <= adc_cfg_pkg::RST_ZERO[adc_cfg_pkg::BIT_SYNCCLR];
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_SYNCCLR)
			syncClr_q <= wrByte[adc_cfg_pkg::BIT_SYNCCLR];
	end

	always_ff @(posedge core_clk)
	begin
		if (regRst)
			term_q <= adc_cfg_pkg::RST_ZERO[1:0];
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_TERM)
		begin
			term_q[0] <= wrByte[adc_cfg_pkg::BIT_TERM_A];
			term_q[1] <= wrByte[adc_cfg_pkg::BIT_TERM_B];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (regRst)
		begin
			sticky_q <= adc_cfg_pkg::RST_ZERO[adc_cfg_pkg::BIT_STICKY];
			ovrClr_q <= adc_cfg_pkg::RST_ZERO[1:0];
		end
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_OVRCTL)
		begin
			sticky_q <= wrByte[adc_cfg_pkg::BIT_STICKY];
			ovrClr_q <= wrByte[adc_cfg_pkg::BIT_CLR_HI:adc_cfg_pkg::BIT_CLR_LO];
		end
	end

	assign ovrClrPulse = wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_OVRCTL
		&& wrByte[adc_cfg_pkg::BIT_CLR_HI:adc_cfg_pkg::BIT_CLR_LO] == adc_cfg_pkg::OVR_CLR_CODE;

	always_ff @(posedge core_clk)
	begin
		if (regRst)
			ovrLen_q <= LEN_W'(adc_cfg_pkg::RST_OVRLEN);
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_OVRLEN)
			ovrLen_q <= LEN_W'(wrByte);
	end

	// link termination, half swing, channel order
	always_ff @(posedge core_clk)
	begin
		if (regRst)
		begin
			linkTerm_q  <= adc_cfg_pkg::RST_OUTCTL[adc_cfg_pkg::BIT_LINKTERM];
			halfSwing_q <= adc_cfg_pkg::RST_OUTCTL[adc_cfg_pkg::BIT_HALFSWING];
			order_q     <= adc_cfg_pkg::RST_OUTCTL[adc_cfg_pkg::BIT_ORDER];
		end
		else if (wrAccess && hit && wrLane && regIdx == adc_cfg_pkg::IDX_OUTCTL)
		begin
			linkTerm_q  <= wrByte[adc_cfg_pkg::BIT_LINKTERM];
			halfSwing_q <= wrByte[adc_cfg_pkg::BIT_HALFSWING];
			order_q     <= wrByte[adc_cfg_pkg::BIT_ORDER];
		end
	end

	// ----------------------------------------
	// Sync reference detection
	// ----------------------------------------
	// Three-stage pin synchroniser
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end
		else if (clkEn)
		begin
			sync1_q <= syncRefPin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Level taken once stages two and three agree
	always_ff @(posedge core_clk)
	begin
		if (reset)
			syncLvl_q <= 1'b0;
		else if (clkEn && sync2_q == sync3_q)
			syncLvl_q <= sync3_q;
	end

	assign syncRise = sync2_q && sync3_q && !syncLvl_q;

	// flag set by edge, reset by held clear
	always_ff @(posedge core_clk)
	begin
		if (regRst)
			syncFlag_q <= 1'b0;
		else if (clkEn)
		begin
			// Event wins over clear
			if (syncRise)
				syncFlag_q <= 1'b1;
			else if (syncClr_q)
				syncFlag_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Fuse load
	// ----------------------------------------
	// ready after hardware reset only
	fuse_loader
	#(
		.LOAD_CYCLES (FUSE_LOAD_CYCLES)
	)
	uFuse
	(
		.core_clk    (core_clk),
		.reset       (reset),
		.clkEn       (clkEn),
		.configReady (ready)
	);

	// ----------------------------------------
	// Overrange per channel
	// ----------------------------------------
	assign chan[0] = sampleIn.chanA;
	assign chan[1] = sampleIn.chanB;

	generate
		for (genvar c = 0; c < 2; c++)
		begin : gOvr
			assign rawOvr[c] = sampleIn.valid && (chan[c] == adc_cfg_pkg::FULL_SCALE_HI
				|| chan[c] == adc_cfg_pkg::FULL_SCALE_LO);

			overrange_stretch
			#(
				.LEN_W (LEN_W)
			)
			uStretch
			(
				.core_clk   (core_clk),
				.reset      (regRst),
				.clkEn      (clkEn),
				.rawEvent   (rawOvr[c]),
				.sticky     (sticky_q),
				.clearPulse (ovrClrPulse),
				.length     (ovrLen_q),
				.overrange  (overrange[c])
			);
		end
	endgenerate

	// ----------------------------------------
	// Channel order
	// ----------------------------------------
	// swap channels when order bit low
	always_ff @(posedge core_clk)
	begin
		if (regRst)
			sampleOut_q <= '0;
		else if (clkEn)
		begin
			sampleOut_q.valid <= sampleIn.valid;
			sampleOut_q.chanA <= order_q ? sampleIn.chanA : sampleIn.chanB;
			sampleOut_q.chanB <= order_q ? sampleIn.chanB : sampleIn.chanA;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Register read mux
	always_comb
	begin
		rdByte = adc_cfg_pkg::RST_ZERO;
		unique case (regIdx)
			adc_cfg_pkg::IDX_READY:   rdByte[adc_cfg_pkg::BIT_READY]   = ready;
			adc_cfg_pkg::IDX_SOFTRST: rdByte[adc_cfg_pkg::BIT_SOFTRST] = softRst_q;
			adc_cfg_pkg::IDX_PDN:     rdByte[adc_cfg_pkg::BIT_PDN]     = pdn_q;
			adc_cfg_pkg::IDX_SYNCCLR: rdByte[adc_cfg_pkg::BIT_SYNCCLR] = syncClr_q;
			adc_cfg_pkg::IDX_TERM:
			begin
				rdByte[adc_cfg_pkg::BIT_TERM_A] = term_q[0];
				rdByte[adc_cfg_pkg::BIT_TERM_B] = term_q[1];
			end
			adc_cfg_pkg::IDX_OVRCTL:
			begin
				rdByte[adc_cfg_pkg::BIT_STICKY] = sticky_q;
				rdByte[adc_cfg_pkg::BIT_CLR_HI:adc_cfg_pkg::BIT_CLR_LO] = ovrClr_q;
			end
			adc_cfg_pkg::IDX_OVRLEN:  rdByte = 8'(ovrLen_q);
			adc_cfg_pkg::IDX_OUTCTL:
			begin
				rdByte[adc_cfg_pkg::BIT_LINKTERM]  = linkTerm_q;
				rdByte[adc_cfg_pkg::BIT_HALFSWING] = halfSwing_q;
				rdByte[adc_cfg_pkg::BIT_ORDER]     = order_q;
			end
			adc_cfg_pkg::IDX_FLAGS:   rdByte[adc_cfg_pkg::BIT_SYNCFLAG] = syncFlag_q;
			default:                  rdByte = adc_cfg_pkg::RST_ZERO;
		endcase
	end

	// Read data and error captured in setup
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end
		else if (clkEn && setupPhase)
		begin
			prdata_q  <= (hit && !pwrite) ? {24'h000000, rdByte} : '0;
			pslverr_q <= !hit;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata      = prdata_q;
	assign pslverr     = pslverr_q;
	assign sampleOut   = sampleOut_q;
	assign configReady = ready;

	assign analogCtrl.globalPowerdown       = pdn_q;
	assign analogCtrl.chanAInputTermination = term_q[0];
	assign analogCtrl.chanBInputTermination = term_q[1];
	assign analogCtrl.linkTerm100           = linkTerm_q;
	assign analogCtrl.halfSwing             = halfSwing_q;

endmodule : adc_config_status_register_bank

// >>> sim/adc_cfg_asserts.sv
// Port checker of the converter register bank.
// Assumes it is bound onto the bank top module.
`timescale 1ns/1ps

module adc_cfg_asserts
(
	// Clock and control
	input wire logic                      core_clk,
	input wire logic                      reset,
	input wire logic                      clkEn,
	// APB
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [13:0]               paddr,
	input wire logic [31:0]               pwdata,
	input wire logic [3:0]                pstrb,
	input wire logic [31:0]               prdata,
	// Sample path and controls
	input wire adc_cfg_pkg::sample_pair_s sampleIn,
	input wire adc_cfg_pkg::sample_pair_s sampleOut,
	input wire logic [1:0]                overrange,
	input wire adc_cfg_pkg::analog_ctrl_s analogCtrl,
	input wire logic                      configReady
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic softPend_q; // Soft reset lands at next edge

	// Accepted write to one register
	sequence s_wr(logic [11:0] i);
		psel && penable && pwrite && clkEn && pstrb[0] && paddr == {i, 2'h0};
	endsequence
	// Soft reset write, then an enabled edge
	sequence s_soft;
		s_wr(adc_cfg_pkg::IDX_SOFTRST) ##0 pwdata[0] ##1 clkEn;
	endsequence

	// Marks the cycle before the soft reset edge
	always_ff @(posedge core_clk)
		if (reset)
			softPend_q <= 1'b0;
		else if (clkEn)
			softPend_q <= psel && penable && pwrite && pstrb[0] && pwdata[0]
				&& paddr == {adc_cfg_pkg::IDX_SOFTRST, 2'h0};

	property p_readyHold; configReady |=> configReady; endproperty
	a_readyHold: assert property (p_readyHold) else $error("ready fell");
	property p_readyRead;
		psel && !penable && !pwrite && clkEn && !softPend_q
			&& paddr == {adc_cfg_pkg::IDX_READY, 2'h0}
			|=> prdata == {27'h0, $past(configReady), 4'h0};
	endproperty
	a_readyRead: assert property (p_readyRead) else $error("ready read");
	property p_softRst; s_soft |=> analogCtrl == '0; endproperty
	a_softRst: assert property (p_softRst) else $error("soft reset");
	property p_pdn;
		s_wr(adc_cfg_pkg::IDX_PDN) |=> analogCtrl.globalPowerdown == $past(pwdata[4]);
	endproperty
	a_pdn: assert property (p_pdn) else $error("power down");
	property p_term;
		s_wr(adc_cfg_pkg::IDX_TERM) |=> {analogCtrl.chanBInputTermination,
			analogCtrl.chanAInputTermination} == $past(pwdata[1:0]);
	endproperty
	a_term: assert property (p_term) else $error("termination");
	property p_link;
		s_wr(adc_cfg_pkg::IDX_OUTCTL) |=> {analogCtrl.linkTerm100, analogCtrl.halfSwing}
			== {$past(pwdata[7]), $past(pwdata[5])};
	endproperty
	a_link: assert property (p_link) else $error("link controls");
	property p_swap;
		clkEn && !softPend_q && sampleIn.valid |=> sampleOut.valid
			&& (sampleOut[31:0] == $past(sampleIn[31:0])
			|| {sampleOut.chanB, sampleOut.chanA} == $past(sampleIn[31:0]));
	endproperty
	a_swap: assert property (p_swap) else $error("sample order");
	property p_ovr;
		clkEn && !softPend_q && sampleIn.valid && (sampleIn.chanA == 16'h7FFF
			|| sampleIn.chanA == 16'h8000) |=> overrange[0];
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrange event");
endmodule : adc_cfg_asserts

bind adc_config_status_register_bank adc_cfg_asserts chk (.core_clk, .reset, .clkEn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .sampleIn, .sampleOut, .overrange,
	.analogCtrl, .configReady);

// >>> sim/host_apb_model.sv
// Host model: APB master, one transfer per request pulse.
// Assumes one request at a time.
`timescale 1ns/1ps

module host_apb_model
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Request side
	input  wire logic        req,
	input  wire logic        reqWrite,
	input  wire logic [13:0] reqAddr,
	input  wire logic [31:0] reqData,
	output logic             done = 1'b0,
	output logic [31:0]      rdata,
	output logic             err,
	// APB master side
	output logic             psel = 1'b0,
	output logic             penable = 1'b0,
	output logic             pwrite = 1'b0,
	output logic [13:0]      paddr = 14'h0,
	output logic [31:0]      pwdata = 32'h0,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// Setup, access, release when pready seen
	always @(posedge core_clk)
	begin
		done <= 1'b0;
		if (reset)
		begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
		else if (psel && penable && pready)
		begin
			rdata <= prdata;
			err <= pslverr;
			done <= 1'b1;
			psel <= 1'b0;
			penable <= 1'b0;
			pwdata <= ~pwdata; // Released bus shows no stale data
		end
		else if (psel)
			penable <= 1'b1;
		else if (req)
		begin
			psel <= 1'b1;
			pwrite <= reqWrite;
			paddr <= reqAddr;
			pwdata <= reqData;
		end
	end
endmodule : host_apb_model

// >>> sim/adc_config_status_register_bank_tb.sv
// Self-checking bench of the converter register bank.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps

module adc_config_status_register_bank_tb;
	logic                      core_clk, reset, clkEn, req, reqWrite, done, err, e;
	logic                      psel, penable, pwrite, pready, pslverr, syncRefPin, configReady;
	logic [13:0]               reqAddr, paddr;
	logic [31:0]               reqData, rdata, pwdata, prdata, rv, v, seed;
	logic [1:0]                overrange;
	adc_cfg_pkg::sample_pair_s sampleIn, sampleOut;
	adc_cfg_pkg::analog_ctrl_s analogCtrl;
	int                        fails, samplesChecked, cycles, n, k;
	int                        regs[int]; // Expected register contents
	int                        idxs[6] = '{12'h101, 12'h102, 12'h104, 12'h10A, 12'h10B, 12'h110};

	adc_config_status_register_bank #(.FUSE_LOAD_CYCLES(8)) DUT (.core_clk, .reset, .clkEn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr,
		.sampleIn, .sampleOut, .overrange, .syncRefPin, .analogCtrl, .configReady);
	host_apb_model host (.core_clk, .reset, .req, .reqWrite, .reqAddr, .reqData, .done,
		.rdata, .err, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] maskOf(int i);
		case (i)
			12'h101: return 8'h10;
			12'h102: return 8'h40;
			12'h104: return 8'h03;
			12'h10A: return 8'h07;
			12'h10B: return 8'hFF;
			12'h110: return 8'hA2;
			default: return 8'h00;
		endcase
	endfunction : maskOf
	// Expected analog controls from the model
	function automatic logic [31:0] ctlExp();
		return {regs[12'h101][4], regs[12'h104][1], regs[12'h104][0], regs[12'h110][7],
			regs[12'h110][5]};
	endfunction : ctlExp
	task automatic resetModel();
		foreach (idxs[j]) regs[idxs[j]] = 0;
		regs[12'h110] = 2;
	endtask : resetModel
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// One bus transfer through the host model
	task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
		req <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		@(posedge core_clk);
		req <= 1'b0;
		// Only the bench timeout ends a hung wait
		while (done !== 1'b1) @(posedge core_clk);
		rv = rdata;
		e = err;
	endtask : apb
	task automatic wr(logic [11:0] i, logic [31:0] d);
		apb(1'b1, {i, 2'h0}, d);
		regs[i] = d & maskOf(i);
	endtask : wr
	task automatic rdC(logic [11:0] i, logic [31:0] exp);
		apb(1'b0, {i, 2'h0}, 32'h0);
		chk("prdata", rv, exp);
	endtask : rdC
	task automatic print_verdict();
		if (fails == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// Clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			fails++;
			print_verdict();
		end
	end

	initial
	begin
		{reset, clkEn, req, reqWrite, reqAddr, reqData, sampleIn, syncRefPin} = '0;
		reset = 1'b1;
		clkEn = 1'b1;
		seed = 32'h1423E75C;
		resetModel();
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk("configReady", configReady, 0);
		rdC(12'h025, 32'h0);
		repeat (10) @(posedge core_clk);
		rdC(12'h025, 32'h10);
		foreach (idxs[j]) rdC(idxs[j], regs[idxs[j]]);
		// Random register traffic
		repeat (24)
		begin
			v = rnd();
			k = v[31:16] % 6;
			wr(idxs[k], v);
			rdC(idxs[k], regs[idxs[k]]);
			chk("analogCtrl", analogCtrl, ctlExp());
		end
		// Unmapped and unaligned reads refused
		apb(1'b0, 14'h0800, 32'h0);
		chk("pslverr", e, 1);
		apb(1'b0, 14'h0405, 32'h0);
		chk("pslverr", e, 1);
		chk("prdata", rv, 0);
		// Stretch length per channel
		for (int c = 0; c < 2; c++)
		begin
			v = rnd();
			wr(12'h10A, 32'h0);
			wr(12'h10B, v[2:0]);
			sampleIn <= c ? {1'b1, 16'h0, 16'h8000} : {1'b1, 16'h7FFF, 16'h0};
			@(posedge core_clk);
			sampleIn <= '0;
			n = 0;
			repeat (12)
			begin
				@(posedge core_clk);
				n += (overrange[c] === 1'b1);
			end
			chk("ovrCycles", n, v[2:0] + 1);
		end
		// Sticky hold and clear code
		wr(12'h10A, 32'h1);
		sampleIn <= {1'b1, 16'h7FFF, 16'h0};
		@(posedge core_clk);
		sampleIn <= '0;
		repeat (20) @(posedge core_clk);
		chk("ovrSticky", overrange[0], 1);
		wr(12'h10A, 32'h5);
		chk("ovrClear", overrange[0], 0);
		// Channel order, swapped then normal
		for (int o = 0; o < 2; o++)
		begin
			wr(12'h110, o ? 32'h2 : 32'h0);
			v = rnd() & 32'h3FFF3FFF;
			sampleIn <= {1'b1, v};
			repeat (2) @(posedge core_clk);
			chk("sampleOut", {sampleOut.chanA, sampleOut.chanB}, o ? v : {v[15:0], v[31:16]});
			sampleIn <= '0;
		end
		// Sync detect flag and its clear
		wr(12'h102, 32'h0);
		syncRefPin <= 1'b1;
		repeat (8) @(posedge core_clk);
		syncRefPin <= 1'b0;
		rdC(12'h140, 32'h40);
		wr(12'h102, 32'h40);
		rdC(12'h140, 32'h0);
		wr(12'h102, 32'h0);
		rdC(12'h140, 32'h0);
		// Soft reset restores defaults
		wr(12'h101, 32'h10);
		wr(12'h104, 32'h3);
		wr(12'h100, 32'h1);
		resetModel();
		rdC(12'h100, 32'h0);
		foreach (idxs[j]) rdC(idxs[j], regs[idxs[j]]);
		chk("analogCtrl", analogCtrl, ctlExp());
		chk("configReady", configReady, 1);
		print_verdict();
	end
endmodule : adc_config_status_register_bank_tb
